// ==== core/angle_status_bank.sv ====
// Purpose: Read-side status, fault, caution and measurement words of the angle sensor.
// Assumes: All inputs synchronous to clk; event inputs are one-cycle pulses or levels.
// Notes: One access per cycle; a read answers one cycle later on reg_rdata_q.
// Functional notes
// - Angle word bits 11:0 carry the unsigned PLL angle, 360/4096 degrees per count.
// - Bit 12 of parity words makes the 16-bit word hold an odd count of ones.
// - Angle bit 13 is real-time OR of masked analog and digital undervoltage.
// - Angle bit 14 is set when any unmasked fault or caution bit is set.
// - Status bits 0..3: PLL locked, boot running, hall test running, logic test running.
// - Status bit 4 sets only once EEPROM loaded and startup tests complete.
// - Status bit 5 clears on special action trigger, sets when it completes.
// - Status bit 6 speed blocks low power, bit 7 direction, bits 9:8 die index.
// - Fault bits latch until read then cleared; bit 0 sets on power-on or hard reset.
// - Undervoltage fault bits set again at once while the condition persists.
// - Fault bits 1,4,5,7: weak field, oscillator, uncorrectable EEPROM, lock lost.
// - Fault bits 6,8,9,10: zero-cross timeout, quadrature, averaging, self-test failure.
// - Fault bit 11 shows any unmasked caution bit, forced 0 by its mask.
// - Caution bit 0 sets on turns overflow beyond 256 rotations, any resolution.
// - Caution bit 2 sets when an extended access starts while one is busy.
// - Caution bits 3,1,4,5,8: turns delta, strong field, clipping, corrected EEPROM, slew.
// - Caution bit 6 sets outside -60..180 degrees; temperature saturates there.
// - Caution bit 7 sets when an extended-write command fails.
// - Bad packets discarded; CRC sets caution bit 10, format errors set bit 11.
// - Temperature word is signed 12-bit, 1/8 degree units relative to 25 degrees.
// - Turns word bits 11:0 hold the signed turns count.
// - Turns word bit 13 selects turns source: 1 PLL angle, 0 crossing detector.
// - Fault clear removes only bits returned by a previous read of the fault word.
// - Caution clear removes only bits returned by a previous read of the caution word.
`timescale 1ns/1ns
`include "angle_status_defs.svh"

module angle_status_bank #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic srst,
   // Register access
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata_q,
   output logic reg_rvalid_q,
   // Measurements
   input wire logic [11:0] pll_angle,
   input wire logic [15:0] temp_raw,
   input wire logic [11:0] magnet_gauss,
   input wire logic [11:0] turns_count,
   // Undervoltage and masks
   input wire logic analog_undervolt,
   input wire logic digital_undervolt,
   input wire logic analog_undervolt_mask,
   input wire logic digital_undervolt_mask,
   input wire logic [11:0] fault_mask,
   input wire logic [11:0] caution_mask,
   // Status levels and events
   input wire logic pll_locked_ok,
   input wire logic boot_running,
   input wire logic hall_selftest_running,
   input wire logic logic_selftest_running,
   input wire logic boot_complete_evt,
   input wire logic special_trigger,
   input wire logic special_complete,
   input wire logic lowpower_blocked,
   input wire logic spin_direction,
   input wire logic [1:0] die_index,
   // Fault events
   input wire logic hard_reset_evt,
   input wire logic magnet_weak_fault,
   input wire logic osc_freq_fault,
   input wire logic eeprom_uncorrectable,
   input wire logic zero_cross_timeout,
   input wire logic lock_lost,
   input wire logic quadrature_integrity_fault,
   input wire logic averaging_fault,
   input wire logic selftest_fail,
   // Caution events
   input wire logic turns_overflow,
   input wire logic magnet_strong_fault,
   input wire logic ext_write_go,
   input wire logic ext_read_go,
   input wire logic ext_access_busy,
   input wire logic turns_delta_warning,
   input wire logic clipping_flag,
   input wire logic eeprom_corrected,
   input wire logic ext_command_fail,
   input wire logic slew_limit_warning,
   input wire logic frame_crc_bad,
   input wire logic frame_format_error,
   // Outputs to the datapath and link
   output logic turns_source_select_q,
   output logic packet_discard_q,
   output logic [11:0] temp_saturated_q
);

   // ************************************************************
   // Helpers
   // ************************************************************
   // Fills bit 12 so the whole word has odd weight
   function automatic angle_status_pkg::word_t with_parity(input angle_status_pkg::word_t w);
      angle_status_pkg::word_t r;
      r = w;
      r[`BIT_PARITY] = 1'b0;
      r[`BIT_PARITY] = ~(^r);
      return r;
   endfunction

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      return a == ADDR_W'(ofs);
   endfunction

   // ************************************************************
   // Access decode
   // ************************************************************
   angle_status_pkg::access_e acc;
   wire logic hit_angle;
   wire logic hit_status;
   wire logic hit_fault;
   wire logic hit_caution;
   wire logic hit_temp;
   wire logic hit_magnet;
   wire logic hit_turns;
   wire logic hit_ctrl;
   wire logic rd_fault;
   wire logic rd_caution;
   wire logic wr_turns;
   wire logic clr_fault;
   wire logic clr_caution;
   wire logic clr_status;

   // A read wins when both strobes arrive together
   assign acc = reg_rd ? angle_status_pkg::ACC_READ :
                reg_wr ? angle_status_pkg::ACC_WRITE : angle_status_pkg::ACC_IDLE;
   assign hit_angle = addr_is(reg_addr, `OFS_PLL_ANGLE);
   assign hit_status = addr_is(reg_addr, `OFS_STATUS);
   assign hit_fault = addr_is(reg_addr, `OFS_FAULT);
   assign hit_caution = addr_is(reg_addr, `OFS_CAUTION);
   assign hit_temp = addr_is(reg_addr, `OFS_TEMP);
   assign hit_magnet = addr_is(reg_addr, `OFS_MAGNET);
   assign hit_turns = addr_is(reg_addr, `OFS_TURNS);
   assign hit_ctrl = addr_is(reg_addr, `OFS_CTRL);
   assign rd_fault = (acc == angle_status_pkg::ACC_READ) && hit_fault;
   assign rd_caution = (acc == angle_status_pkg::ACC_READ) && hit_caution;
   assign wr_turns = (acc == angle_status_pkg::ACC_WRITE) && hit_turns;
   assign clr_fault = (acc == angle_status_pkg::ACC_WRITE) && hit_ctrl && reg_wdata[`BIT_CLR_FAULT];
   assign clr_caution = (acc == angle_status_pkg::ACC_WRITE) && hit_ctrl && reg_wdata[`BIT_CLR_CAUTION];
   assign clr_status = (acc == angle_status_pkg::ACC_WRITE) && hit_ctrl && reg_wdata[`BIT_CLR_STATUS];

   // ************************************************************
   // State
   // ************************************************************
   logic [10:0] fault_q;
   logic [10:0] fault_d;
   logic [10:0] fault_seen_q;
   logic [10:0] fault_seen_d;
   logic [11:0] caution_q;
   logic [11:0] caution_d;
   logic [11:0] caution_seen_q;
   logic [11:0] caution_seen_d;
   logic boot_done_q;
   logic boot_done_d;
   logic maint_done_q;
   logic maint_done_d;
   logic turns_src_d;
   logic [15:0] rdata_d;
   logic [11:0] temp_sat_d;

   // ************************************************************
   // Temperature saturation
   // ************************************************************
   wire logic temp_low;
   wire logic temp_high;

   assign temp_low = $signed(temp_raw) < $signed(`TEMP_LO_CODE);
   assign temp_high = $signed(temp_raw) > $signed(`TEMP_HI_CODE);
   assign temp_sat_d = temp_low ? 12'(`TEMP_LO_CODE) :
                       temp_high ? 12'(`TEMP_HI_CODE) : temp_raw[11:0];

   // ************************************************************
   // Event vectors
   // ************************************************************
   wire logic [10:0] fault_evt;
   wire logic [11:0] caution_evt;
   wire logic overrun;

   // Level inputs such as undervoltage re-set the bit every cycle they stay high
   assign fault_evt = {selftest_fail, averaging_fault, quadrature_integrity_fault,
                       lock_lost, zero_cross_timeout, eeprom_uncorrectable,
                       osc_freq_fault, digital_undervolt, analog_undervolt,
                       magnet_weak_fault, hard_reset_evt};
   assign overrun = (ext_write_go || ext_read_go) && ext_access_busy;
   assign caution_evt = {frame_format_error, frame_crc_bad, 1'b0,
                         slew_limit_warning, ext_command_fail, temp_low || temp_high,
                         eeprom_corrected, clipping_flag, turns_delta_warning,
                         overrun, magnet_strong_fault, turns_overflow};

   // ************************************************************
   // Latch, snapshot and clear
   // ************************************************************
   // Clearing only the snapshot keeps a fault that arrived after the read visible
   assign fault_d = (fault_q & ~(clr_fault ? fault_seen_q : 11'h000)) | fault_evt;
   assign caution_d = ((caution_q & ~(clr_caution ? caution_seen_q : 12'h000)) | caution_evt)
                      & `CAUTION_USED_MASK;
   assign fault_seen_d = rd_fault ? fault_q : (clr_fault ? 11'h000 : fault_seen_q);
   assign caution_seen_d = rd_caution ? caution_q : (clr_caution ? 12'h000 : caution_seen_q);

   // Set wins over the clear for both done flags
   assign boot_done_d = boot_complete_evt || (boot_done_q && !clr_status);
   assign maint_done_d = special_complete || (maint_done_q && !special_trigger && !clr_status);
   assign turns_src_d = wr_turns ? reg_wdata[`BIT_TURNS_SRC] : turns_source_select_q;

   // ************************************************************
   // Summaries and words
   // ************************************************************
   wire logic uv_summary;
   wire logic caution_summary;
   wire logic [11:0] fault_word12;
   wire logic fault_summary;
   angle_status_pkg::word_t angle_word;
   angle_status_pkg::word_t status_word;
   angle_status_pkg::word_t fault_word;
   angle_status_pkg::word_t caution_word;
   angle_status_pkg::word_t temp_word;
   angle_status_pkg::word_t magnet_word;
   angle_status_pkg::word_t turns_word;

   assign uv_summary = (analog_undervolt && !analog_undervolt_mask) ||
                       (digital_undervolt && !digital_undervolt_mask);
   assign caution_summary = (|(caution_q & ~caution_mask)) && !fault_mask[`BIT_CAUTION_SUM];
   assign fault_word12 = {caution_summary, fault_q};
   assign fault_summary = (|(fault_word12 & ~fault_mask)) || (|(caution_q & ~caution_mask));

   assign angle_word = with_parity({1'b0, fault_summary, uv_summary, 1'b0, pll_angle});
   assign status_word = {6'h00, die_index, spin_direction, lowpower_blocked,
                         maint_done_q, boot_done_q, logic_selftest_running,
                         hall_selftest_running, boot_running, pll_locked_ok};
   assign fault_word = {4'h0, fault_word12};
   assign caution_word = {4'h0, caution_q};
   assign temp_word = {4'h0, temp_saturated_q};
   assign magnet_word = {4'h0, magnet_gauss};
   assign turns_word = with_parity({2'b00, turns_source_select_q, 1'b0, turns_count});

   // ************************************************************
   // Read mux
   // ************************************************************
   always_comb begin
      rdata_d = 16'h0000;
      if (acc == angle_status_pkg::ACC_READ) begin
         if (hit_angle) begin
            rdata_d = angle_word;
         end else if (hit_status) begin
            rdata_d = status_word;
         end else if (hit_fault) begin
            rdata_d = fault_word;
         end else if (hit_caution) begin
            rdata_d = caution_word;
         end else if (hit_temp) begin
            rdata_d = temp_word;
         end else if (hit_magnet) begin
            rdata_d = magnet_word;
         end else if (hit_turns) begin
            rdata_d = turns_word;
         end
      end
   end

   // ************************************************************
   // Flip-flops
   // ************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         fault_q <= `RST_FAULT;
         caution_q <= `RST_CAUTION;
         fault_seen_q <= 11'h000;
         caution_seen_q <= 12'h000;
      end else begin
         fault_q <= fault_d;
         caution_q <= caution_d;
         fault_seen_q <= fault_seen_d;
         caution_seen_q <= caution_seen_d;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         boot_done_q <= 1'b0;
         maint_done_q <= 1'b0;
         turns_source_select_q <= `RST_TURNS_SRC;
         temp_saturated_q <= 12'h000;
      end else begin
         boot_done_q <= boot_done_d;
         maint_done_q <= maint_done_d;
         turns_source_select_q <= turns_src_d;
         temp_saturated_q <= temp_sat_d;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata_q <= 16'h0000;
         reg_rvalid_q <= 1'b0;
         packet_discard_q <= 1'b0;
      end else begin
         reg_rdata_q <= rdata_d;
         reg_rvalid_q <= acc == angle_status_pkg::ACC_READ;
         packet_discard_q <= frame_crc_bad || frame_format_error;
      end
   end

endmodule

// ==== core/angle_status_defs.svh ====
// Purpose: Offsets, field positions, reset values and limits of the status register bank.
// Assumes: 16-bit register words addressed by the byte address of their upper byte.
// Notes: Included by the register bank only; the package does not include it.
`ifndef ANGLE_STATUS_DEFS_SVH
`define ANGLE_STATUS_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_PLL_ANGLE 8'h20
`define OFS_STATUS 8'h22
`define OFS_FAULT 8'h24
`define OFS_CAUTION 8'h26
`define OFS_TEMP 8'h28
`define OFS_MAGNET 8'h2A
`define OFS_TURNS 8'h2C
`define OFS_CTRL 8'h1E

// ************************************************************
// Field positions
// ************************************************************
`define BIT_PARITY 12
`define BIT_UV_SUMMARY 13
`define BIT_FAULT_SUMMARY 14
`define BIT_TURNS_SRC 13
`define BIT_CLR_FAULT 8
`define BIT_CLR_CAUTION 9
`define BIT_CLR_STATUS 10
`define BIT_RESET_FLAG 0
`define BIT_ANALOG_UV 2
`define BIT_DIGITAL_UV 3
`define BIT_CAUTION_SUM 11
`define BIT_OVERRUN 2
`define BIT_TEMP_LIMIT 6
`define BIT_CRC_BAD 10
`define BIT_FORMAT_BAD 11
`define CAUTION_USED_MASK 12'hDFF

// ************************************************************
// Reset values
// ************************************************************
`define RST_FAULT 11'h001
`define RST_CAUTION 12'h000
`define RST_TURNS_SRC 1'h1

// ************************************************************
// Temperature limits, 1/8 degree steps relative to 25 degrees
// ************************************************************
`define TEMP_LO_CODE 16'hFD58
`define TEMP_HI_CODE 16'h04D8

`endif

// ==== core/angle_status_pkg.sv ====
// Purpose: Types shared by the status register bank.
// Assumes: Constants live in angle_status_defs.svh.
// Notes: Holds types only.
package angle_status_pkg;
   typedef logic [15:0] word_t;
   typedef logic [11:0] field12_t;
   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_READ,
      ACC_WRITE
   } access_e;
endpackage

// ==== verif/angle_status_chk.sv ====
// Purpose: Port-level assertions for the status register bank
// Assumes: One clock, srst synchronous active high
// Notes: Bound to every bank instance by name
`timescale 1ns/1ns
module angle_status_chk #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_q,
   input wire logic reg_rvalid_q,
   input wire logic [11:0] pll_angle,
   input wire logic [11:0] turns_count,
   input wire logic analog_undervolt,
   input wire logic digital_undervolt,
   input wire logic analog_undervolt_mask,
   input wire logic digital_undervolt_mask,
   input wire logic pll_locked_ok,
   input wire logic boot_running,
   input wire logic hall_selftest_running,
   input wire logic logic_selftest_running,
   input wire logic frame_crc_bad,
   input wire logic frame_format_error,
   input wire logic turns_source_select_q,
   input wire logic packet_discard_q
);
   // ****
   // Read answers one cycle after the taking edge
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_ang; reg_rd && reg_addr == 8'h20 |=> reg_rdata_q[11:0] == $past(pll_angle); endproperty
   a_ang: assert property (p_ang) else $error("angle field wrong");
   property p_par; reg_rd && (reg_addr == 8'h20 || reg_addr == 8'h2C) |=> ^reg_rdata_q; endproperty
   a_par: assert property (p_par) else $error("word parity even");
   property p_uv; reg_rd && reg_addr == 8'h20 |=> reg_rdata_q[13] ==
      $past(analog_undervolt && !analog_undervolt_mask || digital_undervolt && !digital_undervolt_mask); endproperty
   a_uv: assert property (p_uv) else $error("undervolt summary wrong");
   property p_sta; reg_rd && reg_addr == 8'h22 |=> reg_rdata_q[3:0] ==
      $past({logic_selftest_running, hall_selftest_running, boot_running, pll_locked_ok}); endproperty
   a_sta: assert property (p_sta) else $error("status levels wrong");
   property p_unm; reg_rd && reg_addr == 8'h30 |-> ##1 reg_rvalid_q && reg_rdata_q == 16'h0000; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_src; reg_wr && !reg_rd && reg_addr == 8'h2C |=> turns_source_select_q == $past(reg_wdata[13]); endproperty
   a_src: assert property (p_src) else $error("turns source not written");
   property p_trn; reg_rd && reg_addr == 8'h2C |=> reg_rdata_q[11:0] == $past(turns_count) &&
      reg_rdata_q[13] == $past(turns_source_select_q); endproperty
   a_trn: assert property (p_trn) else $error("turns word wrong");
   property p_disc; 1'b1 |=> packet_discard_q == $past(frame_crc_bad || frame_format_error); endproperty
   a_disc: assert property (p_disc) else $error("discard pulse wrong");
endmodule
bind angle_status_bank angle_status_chk #(.ADDR_W(ADDR_W)) chk_i (.*);

// ==== verif/host_model.sv ====
// Purpose: Host side of the register port
// Assumes: Strobes change just after a rising edge
// Notes: Released address and data are inverted, never left at the last value
`timescale 1ns/1ns
module host_model (
   input wire logic clk,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_q,
   input wire logic reg_rvalid_q
);
   // ****
   // Transfers
   // ****
   initial {reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
   // A read of the fault or caution word also arms the clear of the bits it returned
   task automatic read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      #1;
      d = reg_rvalid_q ? reg_rdata_q : 16'hXXXX;
   endtask
   task automatic write(input logic [7:0] a, input logic [15:0] w);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_addr <= ~a;
      reg_wdata <= ~w;
   endtask
endmodule

// ==== verif/tb_angle_status_bank.sv ====
// Purpose: Self-checking bench for the status register bank
// Assumes: Host model drives the register port
// Notes: Scenarios run in order; latched state carries over
`timescale 1ns/1ns
module tb_angle_status_bank;
   logic clk = 1'h0, srst = 1'h1, reg_rd, reg_wr, reg_rvalid_q, turns_source_select_q, packet_discard_q;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata_q, temp_raw = 16'h0000;
   logic [11:0] temp_saturated_q, pll_angle = 12'h000, magnet_gauss = 12'h000, turns_count = 12'h000;
   logic [11:0] fault_mask = 12'h000, caution_mask = 12'h000;
   logic [1:0] die_index = 2'h0;
   logic analog_undervolt = 1'h0, digital_undervolt = 1'h0, analog_undervolt_mask = 1'h0;
   logic digital_undervolt_mask = 1'h0, pll_locked_ok = 1'h0, boot_running = 1'h0, hall_selftest_running = 1'h0;
   logic logic_selftest_running = 1'h0, boot_complete_evt = 1'h0, special_trigger = 1'h0, special_complete = 1'h0;
   logic lowpower_blocked = 1'h0, spin_direction = 1'h0, hard_reset_evt = 1'h0, magnet_weak_fault = 1'h0;
   logic osc_freq_fault = 1'h0, eeprom_uncorrectable = 1'h0, zero_cross_timeout = 1'h0, lock_lost = 1'h0;
   logic quadrature_integrity_fault = 1'h0, averaging_fault = 1'h0, selftest_fail = 1'h0, turns_overflow = 1'h0;
   logic magnet_strong_fault = 1'h0, ext_write_go = 1'h0, ext_read_go = 1'h0, ext_access_busy = 1'h0;
   logic turns_delta_warning = 1'h0, clipping_flag = 1'h0, eeprom_corrected = 1'h0, ext_command_fail = 1'h0;
   logic slew_limit_warning = 1'h0, frame_crc_bad = 1'h0, frame_format_error = 1'h0;
   int err_total = 0, samples_checked = 0;
   always #2 clk = ~clk;
   angle_status_bank #(.ADDR_W(8)) angle_status_bank_i (.*);
   host_model host_model_i (.*);
   // ****
   // Helpers
   // ****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      host_model_i.read(a, d);
      chk(d, e);
   endtask
   // Parity bit 12 makes the whole word odd
   function automatic logic [15:0] pw(input logic [15:0] w);
      return {w[15:13], ~^{w[15:13], w[11:0]}, w[11:0]};
   endfunction
   task automatic fev(input logic v);
      @(posedge clk) {magnet_weak_fault, osc_freq_fault, eeprom_uncorrectable, zero_cross_timeout, lock_lost,
         quadrature_integrity_fault, averaging_fault, selftest_fail} <= {8{v}};
   endtask
   task automatic cev(input logic v);
      @(posedge clk) {turns_overflow, magnet_strong_fault, ext_write_go, ext_read_go, turns_delta_warning,
         clipping_flag, eeprom_corrected, ext_command_fail, slew_limit_warning, frame_crc_bad,
         frame_format_error} <= {11{v}};
   endtask
   task automatic tally_and_finish;
      if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_reset;
      rd(8'h24, 16'h0001);
      rd(8'h26, 16'h0000);
      rd(8'h2C, pw(16'h2000));
   endtask
   task automatic t_angle;
      @(posedge clk) pll_angle <= 12'hFFF;
      analog_undervolt <= 1'h1;
      rd(8'h20, pw(16'h6FFF));
      @(posedge clk) analog_undervolt_mask <= 1'h1;
      rd(8'h20, pw(16'h4FFF));
      @(posedge clk) analog_undervolt_mask <= 1'h0;
   endtask
   task automatic t_faults;
      fev(1'h1);
      fev(1'h0);
      rd(8'h24, 16'h07F7);
      host_model_i.write(8'h1E, 16'h0100);
      rd(8'h24, 16'h0004);
      @(posedge clk) analog_undervolt <= 1'h0;
      host_model_i.write(8'h1E, 16'h0100);
      rd(8'h24, 16'h0000);
      fev(1'h1);
      fev(1'h0);
      // The read after the last clear returned no bits, so this one must leave all bits
      host_model_i.write(8'h1E, 16'h0100);
      rd(8'h24, 16'h07F2);
      host_model_i.write(8'h1E, 16'h0100);
      rd(8'h24, 16'h0000);
   endtask
   task automatic t_caution;
      @(posedge clk) ext_access_busy <= 1'h1;
      temp_raw <= 16'h8000;
      cev(1'h1);
      cev(1'h0);
      rd(8'h26, 16'h0DFF);
      rd(8'h28, 16'h0D58);
      rd(8'h24, 16'h0800);
      @(posedge clk) fault_mask <= 12'h800;
      caution_mask <= 12'hFFF;
      temp_raw <= 16'h7FFF;
      rd(8'h24, 16'h0000);
      rd(8'h20, pw(16'h0FFF));
      rd(8'h28, 16'h04D8);
      chk({4'h0, temp_saturated_q}, 16'h04D8);
      @(posedge clk) temp_raw <= 16'h0010;
      {fault_mask, caution_mask} <= 24'h000000;
      host_model_i.write(8'h1E, 16'h0200);
      rd(8'h26, 16'h0000);
      rd(8'h28, 16'h0010);
   endtask
   task automatic t_status;
      @(posedge clk) {pll_locked_ok, boot_running, hall_selftest_running, logic_selftest_running} <= 4'hF;
      {lowpower_blocked, spin_direction, die_index} <= 4'hE;
      boot_complete_evt <= 1'h1;
      special_trigger <= 1'h1;
      @(posedge clk) boot_complete_evt <= 1'h0;
      special_trigger <= 1'h0;
      rd(8'h22, 16'h02DF);
      @(posedge clk) special_complete <= 1'h1;
      @(posedge clk) special_complete <= 1'h0;
      rd(8'h22, 16'h02FF);
      @(posedge clk) special_trigger <= 1'h1;
      @(posedge clk) special_trigger <= 1'h0;
      rd(8'h22, 16'h02DF);
      host_model_i.write(8'h1E, 16'h0400);
      rd(8'h22, 16'h02CF);
   endtask
   task automatic t_misc;
      rd(8'h30, 16'h0000);
      @(posedge clk) turns_count <= 12'hA5C;
      magnet_gauss <= 12'h3C1;
      host_model_i.write(8'h2C, 16'h0000);
      rd(8'h2C, pw(16'h0A5C));
      rd(8'h2A, 16'h03C1);
      host_model_i.write(8'h2C, 16'h2000);
      rd(8'h2C, pw(16'h2A5C));
      @(posedge clk) hard_reset_evt <= 1'h1;
      @(posedge clk) hard_reset_evt <= 1'h0;
      rd(8'h24, 16'h0001);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'h0;
      t_reset();
      t_angle();
      t_faults();
      t_caution();
      t_status();
      t_misc();
      tally_and_finish();
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end
endmodule
